//--- hdl/csh_pkg.sv
// Package for the command and status handshake block.
// Assumes a single 200 MHz clock domain and an AXI4-Lite register master.
package csh_pkg;
	// Register byte offsets
	localparam logic [7:0] CSH_OFF_CMD    = 8'h00;
	localparam logic [7:0] CSH_OFF_FLAGS  = 8'h04;
	localparam logic [7:0] CSH_OFF_SPEC   = 8'h08;
	localparam logic [7:0] CSH_OFF_OUTCM  = 8'h0C;
	localparam logic [7:0] CSH_OFF_IRQST  = 8'h10;
	localparam logic [7:0] CSH_OFF_IRQMSK = 8'h14;
	// Command word field positions
	localparam int CSH_CMD_START   = 0;
	localparam int CSH_CMD_CLRERR  = 1;
	localparam int CSH_CMD_DECSTOP = 2;
	localparam int CSH_CMD_PRGSTOP = 3;
	localparam int CSH_CMD_DEVCLR  = 4;
	// Outcome control word field positions
	localparam int CSH_OC_FAULT_START = 0;
	localparam int CSH_OC_FAULT_EXEC  = 1;
	localparam int CSH_OC_BUSY_HIGH   = 2;
	localparam int CSH_OC_DEV_REFUSE  = 3;
	localparam int CSH_OC_LEN_LSB     = 8;
	// Reset values
	localparam logic [31:0] CSH_RST_OUTCM  = 32'h0000_1000;
	localparam logic [31:0] CSH_RST_IRQMSK = 32'h0000_0000;
	// Timing: error clearing takes this long
	localparam int CSH_CLR_TIME_NS = 100;
	localparam int CSH_CLK_NS      = 5;
	localparam logic [7:0] CSH_CLR_CYC = 8'((CSH_CLR_TIME_NS + CSH_CLK_NS - 1) / CSH_CLK_NS);
	// AXI responses
	localparam logic [1:0] CSH_RESP_OKAY   = 2'h0;
	localparam logic [1:0] CSH_RESP_SLVERR = 2'h2;

	// Main function state, Gray along idle -> run -> done
	typedef enum logic [1:0] {
		CSH_IDLE = 2'b00,
		CSH_RUN  = 2'b01,
		CSH_DONE = 2'b11,
		CSH_REF  = 2'b10
	} csh_state_t;

	// Status flags of the main function
	typedef struct packed {
		logic ack;
		logic busy;
		logic invalid;
		logic done;
		logic error;
	} csh_flags_t;

	// Status flags of the special commands
	typedef struct packed {
		logic clearing;
		logic stop_done;
		logic prg_stopped;
		logic dev_invalid;
	} csh_spec_t;
endpackage

//--- hdl/csh_top.sv
// Command bit / status flag handshake engine with AXI4-Lite registers.
// Assumes software acts as controller: writes command bits, polls flags.
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
// How it works
// - Acknowledge flag rises once a rise of the start command bit has been noticed.
// - Busy flag stays high while the function is in progress.
// - Invalid flag rises when start fails due to fault or priority.
// - A higher priority command refuses the start via invalid.
// - Done flag rises when the process ends without fault.
// - Error flag rises on any fault at start or during execution.
// - Error clearing reports only through a clearing-in-progress flag.
// - Decelerate-stop reports through a stop-executed flag.
// - Program-halt reports through a program-stopped flag.
// - Counter clear reports only through an invalid flag on refusal.
// - Invalid stays high for as long as acknowledge stays high.
// - Exactly one of done or error rises at command end.
module csh_top
	import csh_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             irq
);

	// Is this a mapped offset
	function automatic logic csh_mapped(input logic [7:0] a);
		return a == CSH_OFF_CMD || a == CSH_OFF_FLAGS || a == CSH_OFF_SPEC ||
			a == CSH_OFF_OUTCM || a == CSH_OFF_IRQST || a == CSH_OFF_IRQMSK;
	endfunction

	logic [7:0]  awaddr_q;
	logic        aw_have_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	logic        w_have_q;
	logic        wr_fire;
	logic        rd_fire;
	logic [4:0]  cmd_q;
	logic [31:0] outcm_q;
	logic [7:0]  irqmsk_q;
	logic [7:0]  irqst_q;
	logic [7:0]  irq_ev;
	csh_state_t  state_q;
	csh_flags_t  flg_q;
	csh_spec_t   spc_q;
	logic [7:0]  run_cnt_q;
	logic [7:0]  clr_cnt_q;
	logic        start_seen_q;
	logic        start_rise;
	logic        prio_block;
	logic        err_set;
	logic        dev_seen_q;
	logic        stop_seen_q;
	logic        prg_seen_q;

	// Write channels taken in either order, response follows both
	assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
	assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
	assign wr_fire       = aw_have_q && w_have_q && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q    <= 1'b0;
			w_have_q     <= 1'b0;
			awaddr_q     <= 8'h00;
			wdata_q      <= 32'h0000_0000;
			wstrb_q      <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= CSH_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_q <= 1'b1;
				wdata_q  <= s_axi_wdata;
				wstrb_q  <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_have_q    <= 1'b0;
				w_have_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= csh_mapped(awaddr_q) ? CSH_RESP_OKAY : CSH_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Software-written control registers, low byte lane steers command bits
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmd_q    <= 5'h00;
			outcm_q  <= CSH_RST_OUTCM;
			irqmsk_q <= CSH_RST_IRQMSK[7:0];
		end else if (wr_fire) begin
			if (awaddr_q == CSH_OFF_CMD && wstrb_q[0])
				cmd_q <= wdata_q[4:0];
			if (awaddr_q == CSH_OFF_OUTCM) begin
				for (int i = 0; i < 4; i++)
					if (wstrb_q[i])
						outcm_q[i*8 +: 8] <= wdata_q[i*8 +: 8];
			end
			if (awaddr_q == CSH_OFF_IRQMSK && wstrb_q[0])
				irqmsk_q <= wdata_q[7:0];
		end
	end

	// A pending clear or stop outranks a normal start
	assign start_rise = cmd_q[CSH_CMD_START] && !start_seen_q;
	assign prio_block = cmd_q[CSH_CMD_CLRERR] || cmd_q[CSH_CMD_DECSTOP] || cmd_q[CSH_CMD_PRGSTOP];

	// A fault caught in the same cycle as the end of clearing must not be lost
	assign err_set = (state_q == CSH_IDLE && start_rise && outcm_q[CSH_OC_FAULT_START]) ||
		(state_q == CSH_RUN && (cmd_q[CSH_CMD_DECSTOP] || run_cnt_q == 8'h00) &&
		outcm_q[CSH_OC_FAULT_EXEC]);

	// Main function handshake: ack, busy, invalid, done, error
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q      <= CSH_IDLE;
			flg_q        <= '0;
			run_cnt_q    <= 8'h00;
			start_seen_q <= 1'b0;
		end else begin
			start_seen_q <= cmd_q[CSH_CMD_START];
			case (state_q)
				CSH_IDLE: begin
					if (start_rise) begin
						flg_q.ack  <= 1'b1;
						flg_q.done <= 1'b0;
						if (prio_block || outcm_q[CSH_OC_FAULT_START] || flg_q.error) begin
							flg_q.invalid <= 1'b1;
							flg_q.error   <= flg_q.error || outcm_q[CSH_OC_FAULT_START];
							state_q       <= CSH_REF;
						end else begin
							flg_q.busy <= 1'b1;
							run_cnt_q  <= outcm_q[CSH_OC_LEN_LSB +: 8];
							state_q    <= CSH_RUN;
						end
					end
				end
				CSH_RUN: begin
					if (cmd_q[CSH_CMD_DECSTOP] || run_cnt_q == 8'h00) begin
						flg_q.busy <= outcm_q[CSH_OC_BUSY_HIGH] && !cmd_q[CSH_CMD_DECSTOP];
						flg_q.error <= outcm_q[CSH_OC_FAULT_EXEC];
						flg_q.done  <= !outcm_q[CSH_OC_FAULT_EXEC];
						state_q     <= CSH_DONE;
					end else begin
						run_cnt_q <= run_cnt_q - 8'h01;
					end
				end
				CSH_DONE: begin
					flg_q.busy <= 1'b0;
					if (!cmd_q[CSH_CMD_START]) begin
						flg_q.ack <= 1'b0;
						state_q   <= CSH_IDLE;
					end
				end
				CSH_REF: begin
					if (!cmd_q[CSH_CMD_START]) begin
						flg_q.ack     <= 1'b0;
						flg_q.invalid <= 1'b0;
						state_q       <= CSH_IDLE;
					end
				end
				default: state_q <= CSH_IDLE;
			endcase
			if (spc_q.clearing && clr_cnt_q == 8'h01 && !err_set)
				flg_q.error <= 1'b0;
		end
	end

	// Special commands report through their own single flag
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			spc_q       <= '0;
			clr_cnt_q   <= 8'h00;
			dev_seen_q  <= 1'b0;
			stop_seen_q <= 1'b0;
			prg_seen_q  <= 1'b0;
		end else begin
			dev_seen_q  <= cmd_q[CSH_CMD_DEVCLR];
			stop_seen_q <= cmd_q[CSH_CMD_DECSTOP];
			prg_seen_q  <= cmd_q[CSH_CMD_PRGSTOP];
			// Clearing runs a fixed time so software sees the busy window
			if (cmd_q[CSH_CMD_CLRERR] && !spc_q.clearing && clr_cnt_q == 8'h00) begin
				spc_q.clearing <= 1'b1;
				clr_cnt_q      <= CSH_CLR_CYC;
			end else if (spc_q.clearing) begin
				clr_cnt_q <= clr_cnt_q - 8'h01;
				if (clr_cnt_q == 8'h01)
					spc_q.clearing <= 1'b0;
			end
			if (cmd_q[CSH_CMD_DECSTOP] && !stop_seen_q)
				spc_q.stop_done <= 1'b1;
			else if (!cmd_q[CSH_CMD_DECSTOP])
				spc_q.stop_done <= 1'b0;
			if (cmd_q[CSH_CMD_PRGSTOP] && !prg_seen_q)
				spc_q.prg_stopped <= 1'b1;
			else if (!cmd_q[CSH_CMD_PRGSTOP])
				spc_q.prg_stopped <= 1'b0;
			// Refused while the axis is moving or forced by software
			if (cmd_q[CSH_CMD_DEVCLR] && !dev_seen_q)
				spc_q.dev_invalid <= outcm_q[CSH_OC_DEV_REFUSE] || flg_q.busy;
			else if (!cmd_q[CSH_CMD_DEVCLR])
				spc_q.dev_invalid <= 1'b0;
		end
	end

	// Sticky event bits; a read of the status clears, a new event wins
	assign irq_ev = {1'b0, spc_q.dev_invalid, spc_q.prg_stopped, spc_q.stop_done,
		flg_q.error, flg_q.done, flg_q.invalid, flg_q.ack};
	logic [7:0] irq_ev_q;
	logic       st_rd;
	assign st_rd = rd_fire && s_axi_araddr == CSH_OFF_IRQST;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_ev_q <= 8'h00;
			irqst_q  <= 8'h00;
			irq      <= 1'b0;
		end else begin
			irq_ev_q <= irq_ev;
			irqst_q  <= (st_rd ? 8'h00 : irqst_q) | (irq_ev & ~irq_ev_q);
			irq      <= |(((st_rd ? 8'h00 : irqst_q) | (irq_ev & ~irq_ev_q)) & irqmsk_q);
		end
	end

	// Read channel, one read at a time
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_fire       = s_axi_arvalid && s_axi_arready;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= CSH_RESP_OKAY;
		end else if (rd_fire) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= csh_mapped(s_axi_araddr) ? CSH_RESP_OKAY : CSH_RESP_SLVERR;
			case (s_axi_araddr)
				CSH_OFF_CMD:    s_axi_rdata <= {27'h0, cmd_q};
				CSH_OFF_FLAGS:  s_axi_rdata <= {27'h0, flg_q};
				CSH_OFF_SPEC:   s_axi_rdata <= {28'h0, spc_q};
				CSH_OFF_OUTCM:  s_axi_rdata <= outcm_q;
				CSH_OFF_IRQST:  s_axi_rdata <= {24'h0, irqst_q};
				CSH_OFF_IRQMSK: s_axi_rdata <= {24'h0, irqmsk_q};
				default:        s_axi_rdata <= 32'h0000_0000;
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Checks on the handshake
	ack_on_start_a: assert property (@(posedge aclk) disable iff (!aresetn)
		state_q == CSH_IDLE && start_rise |=> flg_q.ack) else $error("ack missing");
	busy_in_run_a: assert property (@(posedge aclk) disable iff (!aresetn)
		state_q == CSH_RUN |-> flg_q.busy) else $error("busy low in run");
	invalid_fault_a: assert property (@(posedge aclk) disable iff (!aresetn)
		state_q == CSH_IDLE && start_rise && outcm_q[CSH_OC_FAULT_START] |=> flg_q.invalid)
		else $error("no invalid on fault");
	invalid_prio_a: assert property (@(posedge aclk) disable iff (!aresetn)
		state_q == CSH_IDLE && start_rise && prio_block |=> flg_q.invalid && !flg_q.busy)
		else $error("priority not refused");
	invalid_with_ack_a: assert property (@(posedge aclk) disable iff (!aresetn)
		flg_q.invalid |-> flg_q.ack) else $error("invalid without ack");
	one_outcome_a: assert property (@(posedge aclk) disable iff (!aresetn)
		state_q == CSH_RUN ##1 state_q == CSH_DONE |-> flg_q.done != flg_q.error)
		else $error("outcome not unique");
	done_no_fault_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(flg_q.done) |-> !$past(outcm_q[CSH_OC_FAULT_EXEC])) else $error("done on fault");
	exec_fault_a: assert property (@(posedge aclk) disable iff (!aresetn)
		state_q == CSH_RUN && run_cnt_q == 8'h00 && outcm_q[CSH_OC_FAULT_EXEC] && !cmd_q[CSH_CMD_DECSTOP]
		|=> flg_q.error) else $error("fault not flagged");
	err_set_wins_a: assert property (@(posedge aclk) disable iff (!aresetn)
		err_set |=> flg_q.error) else $error("error set lost");
	clearing_len_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(spc_q.clearing) |-> spc_q.clearing [*8]) else $error("clearing too short");
	stop_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
		cmd_q[CSH_CMD_DECSTOP] && !stop_seen_q |=> spc_q.stop_done) else $error("stop not shown");
	prg_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
		cmd_q[CSH_CMD_PRGSTOP] && !prg_seen_q |=> spc_q.prg_stopped) else $error("halt not shown");
	dev_refuse_a: assert property (@(posedge aclk) disable iff (!aresetn)
		cmd_q[CSH_CMD_DEVCLR] && !dev_seen_q && outcm_q[CSH_OC_DEV_REFUSE] |=> spc_q.dev_invalid)
		else $error("refusal not shown");
	ack_drop_a: assert property (@(posedge aclk) disable iff (!aresetn)
		state_q == CSH_DONE && !cmd_q[CSH_CMD_START] |=> !flg_q.ack ##1 !flg_q.ack [*1])
		else $error("ack stuck");
	run_cv: cover property (@(posedge aclk) disable iff (!aresetn)
		state_q == CSH_RUN ##[1:300] flg_q.done);
	refuse_cv: cover property (@(posedge aclk) disable iff (!aresetn) $rose(flg_q.invalid));
	error_cv: cover property (@(posedge aclk) disable iff (!aresetn) $rose(flg_q.error));
	clear_cv: cover property (@(posedge aclk) disable iff (!aresetn) $fell(spc_q.clearing));
	stop_cv: cover property (@(posedge aclk) disable iff (!aresetn) $rose(spc_q.stop_done));
endmodule

//--- tb/csh_ctrl_model.sv
// Software side of the register bus: an AXI4-Lite master with task access.
// Assumes callers enter a task just after a rising edge of aclk.
`timescale 1ns/1ps
module csh_ctrl_model (
	input  wire logic        aclk,
	input  wire logic        s_axi_awready,
	input  wire logic        s_axi_wready,
	input  wire logic [1:0]  s_axi_bresp,
	input  wire logic        s_axi_bvalid,
	input  wire logic        s_axi_arready,
	input  wire logic [31:0] s_axi_rdata,
	input  wire logic [1:0]  s_axi_rresp,
	input  wire logic        s_axi_rvalid,
	output logic [7:0]       s_axi_awaddr,
	output logic             s_axi_awvalid,
	output logic [31:0]      s_axi_wdata,
	output logic [3:0]       s_axi_wstrb,
	output logic             s_axi_wvalid,
	output logic             s_axi_bready,
	output logic [7:0]       s_axi_araddr,
	output logic             s_axi_arvalid,
	output logic             s_axi_rready
);
	// Quiet bus from time zero
	initial begin
		s_axi_awaddr = 8'h00;
		s_axi_awvalid = 1'b0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'h0;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_araddr = 8'h00;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
	end

	// One write; the trailing edge keeps two tasks from driving in one step
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ta;
		logic tw;
		ta = 1'b0;
		tw = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hF;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(ta && tw && s_axi_bvalid)) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) begin
				ta = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				tw = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask

	// One read; data taken at the edge where rvalid is seen
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ta;
		ta = 1'b0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!(ta && s_axi_rvalid)) begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) begin
				ta = 1'b1;
				s_axi_arvalid <= 1'b0;
			end
		end
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask
endmodule

//--- tb/csh_top_test.sv
// Self-checking bench for the command and status handshake block.
// Assumes csh_ctrl_model plays the controller on the register bus.
`timescale 1ns/1ps
module csh_top_test
	import csh_pkg::*;
;
	logic        aclk, aresetn, irq;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	int          fails;
	int          tests_run;

	csh_top uut (
		.aclk          (aclk),
		.aresetn       (aresetn),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.irq           (irq)
	);
	csh_ctrl_model ctrl (
		.aclk          (aclk),
		.s_axi_awready (s_axi_awready),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_rready  (s_axi_rready)
	);

	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end

	task automatic give_verdict;
		if (fails == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g, input logic [31:0] m);
		tests_run++;
		if ((g & m) !== e) begin
			fails++;
			$display("FAIL %s expected %h seen %h", n, e, g & m);
		end
	endtask

	// Read a register and compare the masked bits
	task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		logic [31:0] d;
		logic [1:0]  r;
		ctrl.rd(a, d, r);
		chk(n, e, d, m);
	endtask

	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		ctrl.wr(a, d, r);
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge aclk);
	endtask

	// Reset values and an unmapped address
	task automatic t_reset;
		logic [31:0] d;
		logic [1:0]  r;
		rdc("outcm", CSH_OFF_OUTCM, CSH_RST_OUTCM, 32'hFFFF_FFFF);
		rdc("irqmsk", CSH_OFF_IRQMSK, CSH_RST_IRQMSK, 32'hFFFF_FFFF);
		rdc("flags", CSH_OFF_FLAGS, 32'h0, 32'h1F);
		ctrl.rd(8'h18, d, r);
		chk("bad rresp", 32'(CSH_RESP_SLVERR), 32'(r), 32'h3);
		chk("bad rdata", 32'h0, d, 32'hFFFF_FFFF);
		ctrl.wr(8'h18, 32'h1, r);
		chk("bad bresp", 32'(CSH_RESP_SLVERR), 32'(r), 32'h3);
	endtask

	// Clean run, long enough to catch busy mid-run
	task automatic t_run;
		wreg(CSH_OFF_OUTCM, 32'h0000_4000);
		wreg(CSH_OFF_CMD, 32'h1);
		rdc("run flags", CSH_OFF_FLAGS, 32'h18, 32'h1F);
		wt(80);
		rdc("end flags", CSH_OFF_FLAGS, 32'h12, 32'h1F);
		wreg(CSH_OFF_CMD, 32'h0);
		wt(3);
		rdc("drop flags", CSH_OFF_FLAGS, 32'h02, 32'h1F);
	endtask

	// Fault at start: invalid lasts as long as acknowledge
	task automatic t_refuse;
		wreg(CSH_OFF_OUTCM, 32'h0000_4001);
		wreg(CSH_OFF_CMD, 32'h1);
		rdc("ref flags", CSH_OFF_FLAGS, 32'h14, 32'h1C);
		wt(20);
		rdc("ref hold", CSH_OFF_FLAGS, 32'h14, 32'h1C);
		wreg(CSH_OFF_CMD, 32'h0);
		wt(3);
		rdc("ref drop", CSH_OFF_FLAGS, 32'h0, 32'h14);
		// The start fault left the error flag set; clear it so a run can start
		wreg(CSH_OFF_CMD, 32'h2);
		wreg(CSH_OFF_CMD, 32'h0);
		wt(25);
		rdc("ref clr", CSH_OFF_FLAGS, 32'h0, 32'h01);
	endtask

	// Fault in execution, refused restart, then error clearing
	task automatic t_fault;
		wreg(CSH_OFF_OUTCM, 32'h0000_0402);
		wreg(CSH_OFF_CMD, 32'h1);
		wt(20);
		rdc("err flags", CSH_OFF_FLAGS, 32'h01, 32'h0B);
		wreg(CSH_OFF_CMD, 32'h0);
		wreg(CSH_OFF_CMD, 32'h1);
		rdc("err start", CSH_OFF_FLAGS, 32'h04, 32'h04);
		wreg(CSH_OFF_CMD, 32'h2);
		rdc("clearing", CSH_OFF_SPEC, 32'h8, 32'hF);
		// Drop the bit early: held on, clearing would start over
		wreg(CSH_OFF_CMD, 32'h0);
		wt(30);
		rdc("cleared", CSH_OFF_FLAGS, 32'h0, 32'h01);
		rdc("clr end", CSH_OFF_SPEC, 32'h0, 32'h8);
	endtask

	// Decelerate-stop mid-run, halt, then priority refusal
	task automatic t_stop;
		wreg(CSH_OFF_OUTCM, 32'h0000_4000);
		wreg(CSH_OFF_CMD, 32'h1);
		wreg(CSH_OFF_CMD, 32'h5);
		wt(5);
		rdc("stop spec", CSH_OFF_SPEC, 32'h4, 32'h4);
		rdc("stop flags", CSH_OFF_FLAGS, 32'h02, 32'h0B);
		wreg(CSH_OFF_CMD, 32'h8);
		wt(5);
		rdc("halt spec", CSH_OFF_SPEC, 32'h2, 32'h2);
		wreg(CSH_OFF_CMD, 32'h9);
		rdc("prio flags", CSH_OFF_FLAGS, 32'h14, 32'h1C);
		wreg(CSH_OFF_CMD, 32'h0);
	endtask

	// Counter clear refused, then accepted
	task automatic t_devclr;
		wreg(CSH_OFF_OUTCM, 32'h0000_4008);
		wreg(CSH_OFF_CMD, 32'h10);
		wt(3);
		rdc("dev ref", CSH_OFF_SPEC, 32'h1, 32'h1);
		wreg(CSH_OFF_CMD, 32'h0);
		wreg(CSH_OFF_OUTCM, 32'h0000_0400);
		wreg(CSH_OFF_CMD, 32'h10);
		wt(3);
		rdc("dev ok", CSH_OFF_SPEC, 32'h0, 32'h1);
		wreg(CSH_OFF_CMD, 32'h0);
	endtask

	// Acknowledge event: masked, unmasked, cleared by read
	task automatic t_irq;
		wreg(CSH_OFF_IRQMSK, 32'h0);
		rdc("irqst all", CSH_OFF_IRQST, 32'h7F, 32'hFF);
		rdc("irqst clr", CSH_OFF_IRQST, 32'h0, 32'hFF);
		wreg(CSH_OFF_CMD, 32'h1);
		wt(3);
		chk("irq masked", 32'h0, 32'(irq), 32'h1);
		wreg(CSH_OFF_IRQMSK, 32'h1);
		wt(2);
		chk("irq on", 32'h1, 32'(irq), 32'h1);
		rdc("irqst ack", CSH_OFF_IRQST, 32'h1, 32'h1);
		wt(2);
		chk("irq off", 32'h0, 32'(irq), 32'h1);
		wreg(CSH_OFF_CMD, 32'h0);
	endtask

	// Watchdog well beyond the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge aclk);
		fails++;
		give_verdict;
	end

	initial begin
		fails = 0;
		tests_run = 0;
		aresetn = 1'b0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_reset;
		t_run;
		t_refuse;
		t_fault;
		t_stop;
		t_devclr;
		t_irq;
		give_verdict;
	end
endmodule
